// *** common/simd_move_pkg.sv ***
// Types for the SIMD integer shuffle and move unit
`default_nettype none
package simd_move_pkg;
  typedef enum logic [4:0] {
    op_byte_sign_mask_move,
    op_narrow_word_shuffle,
    op_low_half_word_shuffle,
    op_high_half_word_shuffle,
    op_dword_shuffle,
    op_byte_shuffle,
    op_blend_byte,
    op_blend_word,
    op_low_qword_interleave,
    op_high_qword_interleave,
    op_narrow_to_wide_move,
    op_wide_to_narrow_move,
    op_cvt_float_to_int,
    op_cvt_int_to_float,
    op_round_to_integral,
    op_widen,
    op_xor,
    op_cmp_eq,
    op_sub,
    op_shift_right_logical,
    op_shift_left
  } op_t;

  // Element width for lane operations
  typedef enum logic [1:0] {
    ew_byte,
    ew_word,
    ew_dword,
    ew_qword
  } elem_t;

  // Rounding selection for round_to_integral
  typedef enum logic [1:0] {
    rnd_nearest,
    rnd_down,
    rnd_up,
    rnd_zero
  } rnd_t;

  typedef struct packed {
    op_t          op;
    logic         src_wide;   // 128-bit source, else 64-bit
    elem_t        src_ew;     // Widen: source element width
    elem_t        dst_ew;     // Widen and lane ops: element width
    logic         sign_ext;   // Widen: sign rather than zero extension
    logic         mask_imm;   // Word blend: mask from immediate byte
    rnd_t         rnd;        // Rounding mode carried by the op
    logic [7:0]   immediate_selector_byte;
    logic [5:0]   shift_cnt;
    logic [127:0] dst;        // Destination operand
    logic [127:0] src;        // Source operand
    logic [127:0] implicit_mask_vector_reg;
  } issue_t;

  typedef struct packed {
    logic         valid;
    logic [127:0] data;
  } result_t;
endpackage : simd_move_pkg
`default_nettype wire

// *** common/simd_move_regs.svh ***
// Constants for the SIMD integer shuffle and move unit
`ifndef SIMD_MOVE_REGS_SVH
`define SIMD_MOVE_REGS_SVH
`define VEC_W        128
`define HALF_W       64
`define SEL_FIELD_W  2
`define MASK_HI_ZERO 16'h0000
`define RES_ZERO     128'h0000_0000_0000_0000_0000_0000_0000_0000
`define RES_LATENCY  1
`define SHIFT_CNT_W  6
`define SHUF_IDX_MSB 7
`endif

// *** rtl/simd_lane_fp.sv ***
// One 32-bit lane of float/int conversion and rounding
`default_nettype none
module simd_lane_fp (
  input  wire logic [1:0]  mode,   // 0 f2i, 1 i2f, 2 round
  input  wire logic [1:0]  rnd,
  input  wire logic [31:0] a,
  output logic      [31:0] y
);
  logic        sgn;
  logic [7:0]  ex;
  logic [55:0] mag;
  logic [55:0] ipart;
  logic [55:0] frac;
  logic [55:0] half;
  logic        up;
  logic [31:0] ai;
  logic [31:0] fi;
  integer      sh;
  integer      lz;
  // Combinational lane conversion
  always_comb begin
    sgn   = a[31];
    ex    = a[30:23];
    mag   = '0;
    ipart = '0;
    frac  = '0;
    half  = '0;
    up    = 1'b0;
    ai    = '0;
    fi    = '0;
    sh    = 0;
    lz    = 0;
    y     = '0;
    if (mode == 2'd1) begin
      ai = a[31] ? 32'(-a) : a;
      for (int i = 0; i < 32; i++) begin
        if (ai[i]) begin
          lz = i;
        end
      end
      fi = 32'(ai << (31 - lz));
      if (ai == 32'h0000_0000) begin
        y = 32'h0000_0000;
      end else begin
        y = {a[31], 8'(lz + 127), fi[30:8]};
      end
    end else begin
      sh = int'(ex) - 127;
      if (ex == 8'hff || sh > 30) begin
        y = (mode == 2'd0) ? 32'h8000_0000 : a;
      end else begin
        mag = {32'h0000_0001, a[22:0], 1'b0} >> 0;
        mag = {8'h00, 1'b1, a[22:0], 24'h00_0000};
        if (ex == 8'h00) begin
          mag = '0;
        end
        ipart = (sh >= 0) ? 56'(mag >> (47 - sh)) : 56'h0;
        // Below one the hidden bit is fraction too; tiny values stay sticky
        if (sh >= 0) begin
          frac = 56'(mag << (sh + 9));
        end else if (sh < -56) begin
          frac = 56'(ex != 8'h00);
        end else begin
          frac = 56'({mag, 9'h000} >> (-sh));
        end
        half = 56'h80_0000_0000_0000;
        case (rnd)
          2'd0: up = (frac > half) || (frac == half && ipart[0]);
          2'd1: up = sgn && (frac != 56'h0);
          2'd2: up = !sgn && (frac != 56'h0);
          default: up = 1'b0;
        endcase
        ipart = ipart + 56'(up);
        if (mode == 2'd0) begin
          y = sgn ? 32'(-ipart[31:0]) : ipart[31:0];
        end else begin
          ai = sgn ? 32'(-ipart[31:0]) : ipart[31:0];
          for (int i = 0; i < 32; i++) begin
            if (ipart[i]) begin
              lz = i;
            end
          end
          fi = 32'(ipart[31:0] << (31 - lz));
          y  = (ipart == 56'h0) ? {sgn, 31'h0}
                                : {sgn, 8'(lz + 127), fi[30:8]};
        end
      end
    end
  end
endmodule : simd_lane_fp
`default_nettype wire

// *** rtl/simd_move_unit.sv ***
// SIMD integer shuffle, blend, move, convert and constant-idiom datapath
`default_nettype none
`include "simd_move_regs.svh"
module simd_move_unit
  import simd_move_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  input  wire logic                  issue_valid,
  input  wire simd_move_pkg::issue_t issue,
  output var simd_move_pkg::result_t result
);
  import simd_move_pkg::*;

  result_t      result_reg;
  result_t      result_next;
  logic [127:0] res;
  logic [127:0] cvt_y;
  logic [1:0]   cvt_mode;
  logic [127:0] a;
  logic [127:0] b;
  logic [7:0]   sel;
  logic [15:0]  bmask;
  logic [7:0]   wmask;

  assign a   = issue.dst;
  assign b   = issue.src;
  assign sel = issue.immediate_selector_byte;

  // Conversion mode per op
  always_comb begin
    case (issue.op)
      op_cvt_float_to_int:  cvt_mode = 2'd0;
      op_cvt_int_to_float:  cvt_mode = 2'd1;
      default:              cvt_mode = 2'd2;
    endcase
  end

  // Four parallel conversion lanes
  for (genvar g = 0; g < 4; g++) begin : g_fp
    simd_lane_fp u_lane (
      .mode (cvt_mode),
      .rnd  (issue.rnd),
      .a    (b[32*g +: 32]),
      .y    (cvt_y[32*g +: 32])
    );
  end

  // Blend masks: byte mask from implicit register, word mask from immediate or implicit register
  always_comb begin
    bmask = '0;
    wmask = '0;
    for (int i = 0; i < 16; i++) begin
      bmask[i] = issue.implicit_mask_vector_reg[8*i+7];
    end
    for (int i = 0; i < 8; i++) begin
      wmask[i] = issue.mask_imm ? sel[i]
                                : issue.implicit_mask_vector_reg[16*i+15];
    end
  end

  // Result selection; no op loads a constant operand
  always_comb begin
    res = `RES_ZERO;
    case (issue.op)
      op_byte_sign_mask_move: begin
        for (int i = 0; i < 16; i++) begin
          if (issue.src_wide || i < 8) begin
            res[i] = b[8*i+7];
          end
        end
        // Upper bits left zero
      end
      op_narrow_word_shuffle: begin
        for (int i = 0; i < 4; i++) begin
          res[16*i +: 16] = b[16*sel[2*i +: 2] +: 16];
        end
      end
      op_low_half_word_shuffle: begin
        res = b;
        for (int i = 0; i < 4; i++) begin
          res[16*i +: 16] = b[16*sel[2*i +: 2] +: 16];
        end
      end
      op_high_half_word_shuffle: begin
        res = b;
        for (int i = 0; i < 4; i++) begin
          res[64+16*i +: 16] = b[64+16*sel[2*i +: 2] +: 16];
        end
      end
      op_dword_shuffle: begin
        for (int i = 0; i < 4; i++) begin
          res[32*i +: 32] = b[32*sel[2*i +: 2] +: 32];
        end
      end
      op_byte_shuffle: begin
        for (int i = 0; i < 16; i++) begin
          if (b[8*i+`SHUF_IDX_MSB]) begin
            res[8*i +: 8] = 8'h00;
          end else begin
            res[8*i +: 8] = a[8*b[8*i +: 4] +: 8];
          end
        end
      end
      op_blend_byte: begin
        for (int i = 0; i < 16; i++) begin
          res[8*i +: 8] = bmask[i] ? b[8*i +: 8] : a[8*i +: 8];
        end
      end
      op_blend_word: begin
        for (int i = 0; i < 8; i++) begin
          res[16*i +: 16] = wmask[i] ? b[16*i +: 16]
                                     : a[16*i +: 16];
        end
      end
      op_low_qword_interleave:
        res = {b[63:0], a[63:0]};
      op_high_qword_interleave:
        res = {b[127:64], a[127:64]};
      op_narrow_to_wide_move:
        res = {64'h0, b[63:0]};
      op_wide_to_narrow_move:
        res = {64'h0, b[63:0]};
      op_cvt_float_to_int, op_cvt_int_to_float,
      op_round_to_integral:
        res = cvt_y;
      op_widen: begin
        // Source elements packed in low lanes
        for (int i = 0; i < 16; i++) begin
          case ({issue.src_ew, issue.dst_ew})
            {ew_byte, ew_word}: if (i < 8)
              res[16*i +: 16] = {{8{issue.sign_ext & b[8*i+7]}},
                                 b[8*i +: 8]};
            {ew_byte, ew_dword}: if (i < 4)
              res[32*i +: 32] = {{24{issue.sign_ext & b[8*i+7]}},
                                 b[8*i +: 8]};
            {ew_byte, ew_qword}: if (i < 2)
              res[64*i +: 64] = {{56{issue.sign_ext & b[8*i+7]}},
                                 b[8*i +: 8]};
            {ew_word, ew_dword}: if (i < 4)
              res[32*i +: 32] = {{16{issue.sign_ext & b[16*i+15]}},
                                 b[16*i +: 16]};
            {ew_word, ew_qword}: if (i < 2)
              res[64*i +: 64] = {{48{issue.sign_ext & b[16*i+15]}},
                                 b[16*i +: 16]};
            {ew_dword, ew_qword}: if (i < 2)
              res[64*i +: 64] = {{32{issue.sign_ext & b[32*i+31]}},
                                 b[32*i +: 32]};
            default: ;
          endcase
        end
      end
      op_xor:
        res = a ^ b;
      op_cmp_eq: begin
        for (int i = 0; i < 16; i++) begin
          case (issue.dst_ew)
            ew_byte:  res[8*i +: 8] = {8{a[8*i +: 8] == b[8*i +: 8]}};
            ew_word:  if (i < 8) res[16*i +: 16] =
                        {16{a[16*i +: 16] == b[16*i +: 16]}};
            default:  if (i < 4) res[32*i +: 32] =
                        {32{a[32*i +: 32] == b[32*i +: 32]}};
          endcase
        end
      end
      op_sub: begin
        // Per-lane subtract, no borrow across lanes
        for (int i = 0; i < 16; i++) begin
          case (issue.dst_ew)
            ew_byte:  res[8*i +: 8] = 8'(a[8*i +: 8] - b[8*i +: 8]);
            ew_word:  if (i < 8) res[16*i +: 16] =
                        16'(a[16*i +: 16] - b[16*i +: 16]);
            default:  if (i < 4) res[32*i +: 32] =
                        32'(a[32*i +: 32] - b[32*i +: 32]);
          endcase
        end
      end
      op_shift_right_logical, op_shift_left: begin
        // Word or dword lanes only; byte width gives zero
        for (int i = 0; i < 8; i++) begin
          if (issue.dst_ew == ew_word) begin
            res[16*i +: 16] = (issue.op == op_shift_left)
              ? 16'(a[16*i +: 16] << issue.shift_cnt)
              : 16'(a[16*i +: 16] >> issue.shift_cnt);
          end else if (issue.dst_ew == ew_dword && i < 4) begin
            res[32*i +: 32] = (issue.op == op_shift_left)
              ? 32'(a[32*i +: 32] << issue.shift_cnt)
              : 32'(a[32*i +: 32] >> issue.shift_cnt);
          end
        end
      end
      default:
        res = `RES_ZERO;
    endcase
  end

  // Next result
  always_comb begin
    result_next = result_reg;
    if (clk_en) begin
      result_next.valid = issue_valid;
      result_next.data  = issue_valid ? res : result_reg.data;
    end
  end

  // Result register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= '0;
    end else begin
      result_reg <= result_next;
    end
  end

  assign result = result_reg;
endmodule : simd_move_unit
`default_nettype wire

// *** tb/simd_move_unit_sva.sv ***
// Port checker for the SIMD shuffle and move unit
`default_nettype none
module simd_move_unit_sva
  import simd_move_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   issue_valid,
  input  wire simd_move_pkg::issue_t  issue,
  input  wire simd_move_pkg::result_t result
);
  logic        take;
  logic [15:0] msb;
  // Taken ops and byte top bits of the source
  always_comb begin
    take = clk_en && issue_valid;
    for (int i = 0; i < 16; i++) msb[i] = issue.src[8*i+7];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_valid; take |=> result.valid; endproperty
  a_valid: assert property (p_valid) else $error("missing result pulse");
  property p_idle; clk_en && !issue_valid |=> !result.valid; endproperty
  a_idle: assert property (p_idle) else $error("pulse without op");
  property p_hold; !clk_en |=> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("result moved while frozen");
  property p_mask16;
    take && issue.op == op_byte_sign_mask_move && issue.src_wide
      |=> result.data[127:16] == '0 && result.data[15:0] == $past(msb);
  endproperty
  a_mask16: assert property (p_mask16) else $error("wide mask");
  property p_mask8;
    take && issue.op == op_byte_sign_mask_move && !issue.src_wide
      |=> result.data[127:8] == '0 && result.data[7:0] == $past(msb[7:0]);
  endproperty
  a_mask8: assert property (p_mask8) else $error("narrow mask");
  property p_dshuf;
    take && issue.op == op_dword_shuffle |=> result.data[63:32] ==
      $past(issue.src[32*issue.immediate_selector_byte[3:2] +: 32]);
  endproperty
  a_dshuf: assert property (p_dshuf) else $error("dword pick");
  property p_n2w;
    take && issue.op == op_narrow_to_wide_move
      |=> result.data == {64'h0000_0000_0000_0000, $past(issue.src[63:0])};
  endproperty
  a_n2w: assert property (p_n2w) else $error("narrow to wide");
  property p_w2n;
    take && issue.op == op_wide_to_narrow_move
      |=> result.data[63:0] == $past(issue.src[63:0]);
  endproperty
  a_w2n: assert property (p_w2n) else $error("wide to narrow");
  property p_qlo;
    take && issue.op == op_low_qword_interleave
      |=> result.data == {$past(issue.src[63:0]), $past(issue.dst[63:0])};
  endproperty
  a_qlo: assert property (p_qlo) else $error("low interleave");
  property p_qhi;
    take && issue.op == op_high_qword_interleave |=> result.data ==
      {$past(issue.src[127:64]), $past(issue.dst[127:64])};
  endproperty
  a_qhi: assert property (p_qhi) else $error("high interleave");
  property p_xor;
    take && issue.op == op_xor && issue.dst == issue.src |=> result.data == '0;
  endproperty
  a_xor: assert property (p_xor) else $error("self xor");
  property p_cmp;
    take && issue.op == op_cmp_eq && issue.dst == issue.src
      |=> result.data == '1;
  endproperty
  a_cmp: assert property (p_cmp) else $error("self compare");
endmodule : simd_move_unit_sva
bind simd_move_unit simd_move_unit_sva simd_move_unit_sva_inst (
  .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
  .issue_valid(issue_valid), .issue(issue), .result(result));
`default_nettype wire

// *** tb/simd_move_unit_tb.sv ***
// Random self-checking bench for the SIMD shuffle and move unit
`default_nettype none
module simd_move_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import simd_move_pkg::*;
  logic         core_clk = 0;
  logic         nrst = 0;
  logic         clk_en = 0;
  logic         issue_valid = 0;
  issue_t       issue = '0;
  result_t      result;
  logic [15:0]  writes;
  int           fails = 0;
  int           compares = 0;
  int           taken = 0;
  logic [127:0] ed, care;
  logic         ev;
  always #12.5ns core_clk = ~core_clk;
  simd_move_unit simd_move_unit_inst (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .issue_valid(issue_valid), .issue(issue),
    .result(result));
  simd_result_sink simd_result_sink_inst (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .result(result), .writes(writes));
  // Lane ops: no bits cross lane edges; byte shifts give zero
  function automatic logic [127:0] lanes(issue_t t);
    int w;
    logic [127:0] m, a, b, y, r;
    w = 8 << t.dst_ew;
    m = (128'h1 << w) - 1;
    r = '0;
    for (int i = 0; i < 128 / w; i++) begin
      a = (t.dst >> (w * i)) & m;
      b = (t.src >> (w * i)) & m;
      case (t.op)
        op_xor:                 y = a ^ b;
        op_cmp_eq:              y = (a == b) ? m : '0;
        op_sub:                 y = a - b;
        op_shift_right_logical: y = t.dst_ew == ew_byte ? '0 : a >> t.shift_cnt;
        default:                y = t.dst_ew == ew_byte ? '0 : a << t.shift_cnt;
      endcase
      r |= (y & m) << (w * i);
    end
    return r;
  endfunction : lanes
  // Expected result and the bits that are defined
  function automatic logic [127:0] expect_of(issue_t t, output logic [127:0] c);
    logic [127:0] r, e, m;
    logic [7:0]   s;
    int           sw, dw;
    s = t.immediate_selector_byte;
    r = t.src;
    c = '1;
    case (t.op)
      op_byte_sign_mask_move: begin
        r = '0;
        for (int i = 0; i < 16; i++) r[i] = t.src[8*i+7] & (t.src_wide || i < 8);
      end
      op_narrow_word_shuffle, op_low_half_word_shuffle: begin
        if (t.op == op_narrow_word_shuffle) c[127:64] = '0;
        for (int i = 0; i < 4; i++) r[16*i +: 16] = t.src[16*s[2*i +: 2] +: 16];
      end
      op_high_half_word_shuffle:
        for (int i = 0; i < 4; i++)
          r[64+16*i +: 16] = t.src[64+16*s[2*i +: 2] +: 16];
      op_dword_shuffle:
        for (int i = 0; i < 4; i++) r[32*i +: 32] = t.src[32*s[2*i +: 2] +: 32];
      op_byte_shuffle:
        for (int i = 0; i < 16; i++)
          r[8*i +: 8] = t.src[8*i+7] ? 8'h00 : t.dst[8*t.src[8*i +: 4] +: 8];
      op_blend_byte:
        for (int i = 0; i < 16; i++)
          r[8*i +: 8] = t.implicit_mask_vector_reg[8*i+7] ?
                        t.src[8*i +: 8] : t.dst[8*i +: 8];
      op_blend_word:
        for (int i = 0; i < 8; i++)
          r[16*i +: 16] = (t.mask_imm ? s[i] : t.implicit_mask_vector_reg[16*i+15])
                          ? t.src[16*i +: 16] : t.dst[16*i +: 16];
      op_low_qword_interleave:  r = {t.src[63:0], t.dst[63:0]};
      op_high_qword_interleave: r = {t.src[127:64], t.dst[127:64]};
      op_narrow_to_wide_move, op_wide_to_narrow_move:
        r = {64'h0000_0000_0000_0000, t.src[63:0]};
      op_widen: begin
        sw = 8 << t.src_ew;
        dw = 8 << t.dst_ew;
        m = (128'h1 << sw) - 1;
        r = '0;
        for (int i = 0; i < 128 / dw; i++) begin
          e = (t.src >> (sw * i)) & m;
          if (t.sign_ext && e[sw-1]) e |= ~m;
          r |= (e & ((128'h1 << dw) - 1)) << (dw * i);
        end
      end
      default: r = lanes(t);
    endcase
    return r;
  endfunction : expect_of
  // Random op with constant-idiom operands mixed in
  task automatic pick(output issue_t t);
    int k;
    for (int i = 0; i < 13; i++) t = {t, $urandom};
    k = $urandom % 18;
    t.op = op_t'(k < 12 ? k : k + 3);
    t.dst_ew = elem_t'($urandom % 3);
    t.shift_cnt = $urandom % (8 << t.dst_ew);
    t.src_ew = elem_t'($urandom % 3);
    if (t.op == op_widen) t.dst_ew = elem_t'(t.src_ew + 1 + $urandom % (3 - t.src_ew));
    case ($urandom % 4)
      0: t.src = t.dst;
      1: begin
        t.dst = '0;
        t.src = '1;
      end
      2: t.dst = '1;
      default: ;
    endcase
  endtask : pick
  task automatic chk_bit(string n, logic e, logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_vec(string n, logic [127:0] e, logic [127:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Directed conversion on all four lanes, checked one cycle later
  task automatic cvt_case(op_t op, rnd_t r, logic [31:0] x, logic [31:0] e);
    @(negedge core_clk);
    clk_en = 1;
    issue_valid = 1;
    issue.op = op;
    issue.rnd = r;
    issue.src = {4{x}};
    @(negedge core_clk);
    issue_valid = 0;
    taken++;
    chk_bit("cvt valid", 1'b1, result.valid);
    chk_vec("cvt data", {4{e}}, result.data);
  endtask : cvt_case
  // Main sequence: back-to-back ops, idle slots and frozen cycles
  initial begin
    void'($urandom(1548));
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1;
    ev = 0;
    ed = '0;
    care = '1;
    repeat (1500) begin
      @(negedge core_clk);
      chk_bit("result.valid", ev, result.valid);
      chk_vec("result.data", ed & care, result.data & care);
      clk_en = ($urandom % 8) != 0;
      issue_valid = ($urandom % 6) != 0;
      pick(issue);
      if (clk_en) ev = issue_valid;
      if (clk_en && issue_valid) begin
        ed = expect_of(issue, care);
        taken++;
      end
    end
    // Rounding corner cases: ties, signs, values below one
    cvt_case(op_cvt_float_to_int, rnd_nearest,
             32'h4020_0000, 32'h0000_0002);
    cvt_case(op_cvt_float_to_int, rnd_up,
             32'h4020_0000, 32'h0000_0003);
    cvt_case(op_cvt_float_to_int, rnd_nearest,
             32'hbfc0_0000, 32'hffff_fffe);
    cvt_case(op_cvt_float_to_int, rnd_zero,
             32'hbfc0_0000, 32'hffff_ffff);
    cvt_case(op_cvt_float_to_int, rnd_nearest,
             32'h3f00_0000, 32'h0000_0000);
    cvt_case(op_cvt_int_to_float, rnd_nearest,
             32'hffff_fffd, 32'hc040_0000);
    cvt_case(op_round_to_integral, rnd_nearest,
             32'h3f40_0000, 32'h3f80_0000);
    cvt_case(op_round_to_integral, rnd_down,
             32'h3f40_0000, 32'h0000_0000);
    cvt_case(op_round_to_integral, rnd_zero,
             32'hbf40_0000, 32'h8000_0000);
    cvt_case(op_round_to_integral, rnd_up,
             32'h3e80_0000, 32'h3f80_0000);
    @(negedge core_clk);
    clk_en = 1;
    issue_valid = 0;
    repeat (2) @(negedge core_clk);
    chk_vec("writes", 128'(taken), 128'(writes));
    end_sim;
  end
  // Watchdog against a hang
  initial begin
    #(25ns * 3000);
    fails++;
    end_sim;
  end
endmodule : simd_move_unit_tb
`default_nettype wire

// *** tb/simd_result_sink.sv ***
// Register-file write-back model that counts delivered results
`default_nettype none
module simd_result_sink
  import simd_move_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire simd_move_pkg::result_t result,
  output logic [15:0]                 writes
);
  timeunit 1ns;
  timeprecision 1ps;
  // One write per result pulse; a frozen pulse is written once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      writes <= '0;
    end else if (clk_en && result.valid) begin
      writes <= writes + 16'h0001;
    end
  end
endmodule : simd_result_sink
`default_nettype wire
